// ===== t8wm_pkg.sv
/*
 * t8wm_pkg: register map, field layout, modes and constants of the
 * 8-bit waveform timer.
 * Assumes: included before all other files of the block.
 */
package t8wm_pkg;
    localparam int CW = 8;
    localparam logic [CW-1:0] CNT_BOTTOM = 8'h00;
    localparam logic [CW-1:0] CNT_MAX = 8'hFF;

    // register byte offsets on the AXI4-Lite bus
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_COUNT = 5'h04;
    localparam logic [4:0] OFF_COMPARE = 5'h08;
    localparam logic [4:0] OFF_FLAGS = 5'h0C;
    localparam logic [4:0] OFF_CMD = 5'h10;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACT_LSB = 6;
    localparam int CTRL_DIR_BIT = 8;
    localparam int CTRL_EN_BIT = 9;
    // flag register fields (write one to clear)
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_MATCH_BIT = 1;
    // command register: force compare strobe
    localparam int CMD_FORCE_BIT = 0;
    // read-only status bit: wave_out internal state
    localparam int FLAG_WAVE_BIT = 2;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        T8WM_NORMAL = 2'd0,
        T8WM_PHASE_PWM = 2'd1,
        T8WM_CLEAR_ON_MATCH = 2'd2,
        T8WM_FAST_PWM = 2'd3
    } t8wm_mode_type;

    typedef enum logic [1:0] {
        T8WM_ACT_OFF = 2'd0,
        T8WM_ACT_TOGGLE = 2'd1,
        T8WM_ACT_CLEAR = 2'd2,
        T8WM_ACT_SET = 2'd3
    } t8wm_act_type;
endpackage

// ===== t8wm_cfg_if.sv
/*
 * t8wm_cfg_if: settings and strobes passed from the register slave to the
 * counter core.
 * Assumes: both ends run on the same clock.
 */
`timescale 1ns/10ps
interface t8wm_cfg_if;
    import t8wm_pkg::*;
    t8wm_mode_type wave_mode_sel;
    t8wm_act_type out_action_sel;
    logic run_enable;
    logic [CW-1:0] compare_wdata;
    logic compare_write;
    logic [CW-1:0] count_wdata;
    logic count_write;
    logic force_match;
    logic [CW-1:0] count_value;
    logic [CW-1:0] compare_value;
    logic wave_state;
    logic ovf_event;
    logic match_event;

    modport regs (
        output wave_mode_sel, out_action_sel, run_enable, compare_wdata,
        output compare_write, count_wdata, count_write, force_match,
        input count_value, compare_value, wave_state, ovf_event, match_event
    );
    modport core (
        input wave_mode_sel, out_action_sel, run_enable, compare_wdata,
        input compare_write, count_wdata, count_write, force_match,
        output count_value, compare_value, wave_state, ovf_event, match_event
    );
endinterface

// ===== t8wm_axi_regs.sv
/*
 * t8wm_axi_regs: AXI4-Lite slave holding control, flag and command
 * registers of the waveform timer.
 * Assumes: one write and one read in flight at most; same clock as core.
 */
`timescale 1ns/10ps
module t8wm_axi_regs (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // write channels
    input wire logic [4:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // read channels
    input wire logic [4:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // core side
    t8wm_cfg_if.regs cfg,
    output logic o_dir_out
);
    import t8wm_pkg::*;

    logic aw_hold_reg;
    logic [4:0] aw_addr_reg;
    logic w_hold_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_write;
    logic [4:0] wa;
    logic ovf_flag_reg;
    logic match_flag_reg;
    logic [1:0] mode_reg;
    logic [1:0] act_reg;
    logic dir_reg;
    logic en_reg;
    logic [31:0] rd_next;
    logic rd_ok;

    assign o_awready = !aw_hold_reg && !o_bvalid;
    assign o_wready = !w_hold_reg && !o_bvalid;
    assign o_arready = !o_rvalid;
    assign do_write = aw_hold_reg && w_hold_reg && !o_bvalid;
    assign wa = aw_addr_reg;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 5'h00;
        end else if (o_awready && i_awvalid) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= i_awaddr;
        end else if (do_write) begin
            aw_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (o_wready && i_wvalid) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= i_wdata;
            w_strb_reg <= i_wstrb;
        end else if (do_write) begin
            w_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp <= (wa == OFF_CTRL || wa == OFF_COUNT ||
                wa == OFF_COMPARE || wa == OFF_FLAGS || wa == OFF_CMD) ?
                RESP_OKAY : RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // control fields; all sit in byte lane 0 or 1
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mode_reg <= 2'b00;
            act_reg <= 2'b00;
            dir_reg <= 1'b0;
            en_reg <= 1'b0;
        end else if (do_write && wa == OFF_CTRL) begin
            if (w_strb_reg[0]) begin
                mode_reg <= w_data_reg[CTRL_MODE_LSB +: 2];
                act_reg <= w_data_reg[CTRL_ACT_LSB +: 2];
            end
            if (w_strb_reg[1]) begin
                dir_reg <= w_data_reg[CTRL_DIR_BIT];
                en_reg <= w_data_reg[CTRL_EN_BIT];
            end
        end
    end

    assign cfg.wave_mode_sel = t8wm_mode_type'(mode_reg);
    assign cfg.out_action_sel = t8wm_act_type'(act_reg);
    assign cfg.run_enable = en_reg;
    assign o_dir_out = dir_reg;
    assign cfg.compare_wdata = w_data_reg[CW-1:0];
    assign cfg.count_wdata = w_data_reg[CW-1:0];
    assign cfg.compare_write = do_write && wa == OFF_COMPARE && w_strb_reg[0];
    assign cfg.count_write = do_write && wa == OFF_COUNT && w_strb_reg[0];
    assign cfg.force_match = do_write && wa == OFF_CMD && w_strb_reg[0] &&
        w_data_reg[CMD_FORCE_BIT];

    // hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ovf_flag_reg <= 1'b0;
            match_flag_reg <= 1'b0;
        end else begin
            if (cfg.ovf_event) begin
                ovf_flag_reg <= 1'b1;
            end else if (do_write && wa == OFF_FLAGS && w_strb_reg[0] &&
                w_data_reg[FLAG_OVF_BIT]) begin
                ovf_flag_reg <= 1'b0;
            end
            if (cfg.match_event) begin
                match_flag_reg <= 1'b1;
            end else if (do_write && wa == OFF_FLAGS && w_strb_reg[0] &&
                w_data_reg[FLAG_MATCH_BIT]) begin
                match_flag_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        rd_ok = 1'b1;
        case (i_araddr)
            OFF_CTRL: begin
                rd_next[CTRL_MODE_LSB +: 2] = mode_reg;
                rd_next[CTRL_ACT_LSB +: 2] = act_reg;
                rd_next[CTRL_DIR_BIT] = dir_reg;
                rd_next[CTRL_EN_BIT] = en_reg;
            end
            OFF_COUNT: rd_next[CW-1:0] = cfg.count_value;
            OFF_COMPARE: rd_next[CW-1:0] = cfg.compare_value;
            OFF_FLAGS: begin
                rd_next[FLAG_OVF_BIT] = ovf_flag_reg;
                rd_next[FLAG_MATCH_BIT] = match_flag_reg;
                rd_next[FLAG_WAVE_BIT] = cfg.wave_state;
            end
            OFF_CMD: rd_next = 32'h0000_0000;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end else if (o_arready && i_arvalid) begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_next;
            o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end
endmodule

// ===== t8wm_tick_sync.sv
/*
 * t8wm_tick_sync: two-stage synchroniser and rising-edge detector for
 * the timer tick pin.
 * Assumes: the tick pin is slow against i_clock (high or low two cycles).
 */
`timescale 1ns/10ps
module t8wm_tick_sync (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // pin and pulse
    input wire logic i_pin,
    output logic o_pulse
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    assign o_pulse = s2_reg && !s3_reg;
endmodule

// ===== t8wm_timer.sv
/*
 * t8wm_timer: top of the 8-bit waveform timer. Counter, compare unit,
 * waveform generator, pin gating; registers over AXI4-Lite.
 * Assumes: the timer tick comes from an outside prescaler or oscillator
 * as a level on a pin; each rising edge is one timer clock.
 */
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
// What this block does
// RULE_01: mode 2 clears the counter the tick after it matches compare.
// RULE_02: clear-on-match mode raises the match flag each period at top.
// RULE_03: clear-on-match compare unbuffered; written below count, wraps first.
// RULE_04: clear-on-match with action 1 toggles the output on each match.
// RULE_05: toggle with compare zero flips output every tick, half rate.
// RULE_06: clear-on-match sets overflow on the tick rolling max to zero.
// RULE_07: mode 3 counts up only, bottom to max, then restarts.
// RULE_08: fast PWM clears the counter on the tick after max.
// RULE_09: fast PWM sets overflow each time counter reaches max.
// RULE_10: fast PWM action 2 clears on match, sets at bottom; 3 opposite.
// RULE_11: fast PWM compare bottom gives spike; compare max a constant level.
// RULE_12: fast PWM action 1 toggles on each match, 50% duty.
// RULE_13: fast PWM keeps compare double buffering active.
// RULE_14: mode 1 counts up to max then down to bottom repeatedly.
// RULE_15: phase correct reverses at max, holding max one tick.
// RULE_16: phase correct: clear on up-match, set on down-match; inverted swaps.
// RULE_17: phase correct sets overflow each time counter reaches bottom.
// RULE_18: phase correct compare bottom constant low, max constant high.
// RULE_19: output reaches pin only when pin direction is output.
// RULE_20: counter advances only on active timer tick.
// RULE_21: a match sets the match flag on the following tick.
// RULE_22: compare buffered in PWM modes, written directly otherwise.
// RULE_23: mode 0 counts up, wraps 0xFF to 0x00, never clears on match.
// RULE_24: non-PWM action 1/2/3 toggle/clear/set on match; 0 disconnects.
// RULE_25: PWM modes load buffered compare when counter reaches max.
// RULE_26: software sets modes before enabling tick and sets pin direction.
`timescale 1ns/10ps
module t8wm_timer (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // AXI4-Lite write
    input wire logic [4:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read
    input wire logic [4:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // timer tick and waveform pin
    input wire logic i_tick_pin,
    output logic o_wave_out,
    output logic o_wave_oe,
    // event pulses
    output logic o_overflow_pulse,
    output logic o_match_pulse
);
    import t8wm_pkg::*;

    t8wm_cfg_if cfg ();

    logic dir_out;
    logic tick_raw;
    logic tick_enable;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic [CW-1:0] compare_reg;
    logic [CW-1:0] compare_buf_reg;
    logic down_reg;
    logic wave_reg;
    logic wave_next;
    logic block_reg;
    logic match_pend_reg;
    logic is_pwm;
    logic hit;
    logic at_max;
    logic at_bottom;
    logic ovf_now;
    logic ovf_reg;
    logic match_reg;

    t8wm_axi_regs i_t8wm_axi_regs (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_awaddr(i_awaddr),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .o_bresp(o_bresp),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .i_araddr(i_araddr),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .cfg(cfg.regs),
        .o_dir_out(dir_out)
    );

    t8wm_tick_sync i_t8wm_tick_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pin(i_tick_pin),
        .o_pulse(tick_raw)
    );

    // software gate on top of the pin tick
    assign tick_enable = tick_raw && cfg.run_enable; // RULE_20

    assign is_pwm = cfg.wave_mode_sel == T8WM_PHASE_PWM ||
        cfg.wave_mode_sel == T8WM_FAST_PWM;
    assign hit = count_reg == compare_reg;
    assign at_max = count_reg == CNT_MAX;
    assign at_bottom = count_reg == CNT_BOTTOM;

    // counting sequence per mode
    always_comb begin
        count_next = count_reg;
        unique case (cfg.wave_mode_sel)
            T8WM_NORMAL: count_next = count_reg + 8'h01; // RULE_23
            T8WM_CLEAR_ON_MATCH: begin
                // missed top runs on through 0xFF to 0x00
                if (hit) begin
                    count_next = CNT_BOTTOM; // RULE_01
                end else begin
                    count_next = count_reg + 8'h01; // RULE_03
                end
            end
            T8WM_FAST_PWM: begin
                if (at_max) begin
                    count_next = CNT_BOTTOM; // RULE_08
                end else begin
                    count_next = count_reg + 8'h01; // RULE_07
                end
            end
            T8WM_PHASE_PWM: begin
                // max held one tick: direction flips as we leave it
                if (at_max) begin
                    count_next = count_reg - 8'h01; // RULE_15
                end else if (at_bottom) begin
                    count_next = count_reg + 8'h01; // RULE_14
                end else if (down_reg) begin
                    count_next = count_reg - 8'h01;
                end else begin
                    count_next = count_reg + 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_reg <= CNT_BOTTOM;
        end else if (cfg.count_write) begin
            count_reg <= cfg.count_wdata;
        end else if (tick_enable) begin
            count_reg <= count_next; // RULE_20
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            down_reg <= 1'b0;
        end else if (cfg.wave_mode_sel != T8WM_PHASE_PWM) begin
            down_reg <= 1'b0;
        end else if (tick_enable && at_max) begin
            down_reg <= 1'b1; // RULE_15
        end else if (tick_enable && at_bottom) begin
            down_reg <= 1'b0;
        end
    end

    // compare buffer: direct in non-PWM, loaded at max in PWM modes
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            compare_buf_reg <= CNT_BOTTOM;
        end else if (cfg.compare_write) begin
            compare_buf_reg <= cfg.compare_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            compare_reg <= CNT_BOTTOM;
        end else if (!is_pwm) begin
            if (cfg.compare_write) begin
                compare_reg <= cfg.compare_wdata; // RULE_22
            end
        end else if (tick_enable && at_max) begin
            compare_reg <= compare_buf_reg; // RULE_13 RULE_25
        end
    end

    // a count write blocks the match of the next tick
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            block_reg <= 1'b0;
        end else if (cfg.count_write) begin
            block_reg <= 1'b1;
        end else if (tick_enable) begin
            block_reg <= 1'b0;
        end
    end

    // match seen now, flag raised on the following tick
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            match_pend_reg <= 1'b0;
        end else if (tick_enable) begin
            match_pend_reg <= hit && !block_reg; // RULE_21
        end
    end

    always_comb begin
        unique case (cfg.wave_mode_sel)
            T8WM_FAST_PWM: ovf_now = at_max; // RULE_09
            T8WM_PHASE_PWM: ovf_now = at_bottom; // RULE_17
            default: ovf_now = at_max; // RULE_06
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ovf_reg <= 1'b0;
            match_reg <= 1'b0;
        end else begin
            ovf_reg <= tick_enable && ovf_now;
            match_reg <= tick_enable && match_pend_reg; // RULE_02 RULE_21
        end
    end

    assign cfg.ovf_event = ovf_reg;
    assign cfg.match_event = match_reg;
    assign o_overflow_pulse = ovf_reg;
    assign o_match_pulse = match_reg;
    assign cfg.count_value = count_reg;
    assign cfg.compare_value = is_pwm ? compare_buf_reg : compare_reg;
    assign cfg.wave_state = wave_reg;

    // waveform generator; acts on the tick that leaves the compared count
    always_comb begin
        wave_next = wave_reg;
        if (cfg.force_match && !is_pwm) begin
            unique case (cfg.out_action_sel)
                T8WM_ACT_TOGGLE: wave_next = !wave_reg;
                T8WM_ACT_CLEAR: wave_next = 1'b0;
                T8WM_ACT_SET: wave_next = 1'b1;
                T8WM_ACT_OFF: wave_next = wave_reg;
            endcase
        end else if (tick_enable && !block_reg) begin
            unique case (cfg.wave_mode_sel)
                T8WM_NORMAL, T8WM_CLEAR_ON_MATCH: begin
                    if (hit) begin
                        unique case (cfg.out_action_sel) // RULE_24
                            T8WM_ACT_TOGGLE: wave_next = !wave_reg; // RULE_04 RULE_05
                            T8WM_ACT_CLEAR: wave_next = 1'b0;
                            T8WM_ACT_SET: wave_next = 1'b1;
                            T8WM_ACT_OFF: wave_next = wave_reg;
                        endcase
                    end
                end
                T8WM_FAST_PWM: begin
                    // match at max wins over the wrap: constant level
                    unique case (cfg.out_action_sel)
                        T8WM_ACT_TOGGLE: if (hit) wave_next = !wave_reg; // RULE_12
                        T8WM_ACT_CLEAR: begin
                            if (hit) wave_next = 1'b0; // RULE_10 RULE_11
                            else if (at_max) wave_next = 1'b1;
                        end
                        T8WM_ACT_SET: begin
                            if (hit) wave_next = 1'b1; // RULE_10 RULE_11
                            else if (at_max) wave_next = 1'b0;
                        end
                        T8WM_ACT_OFF: wave_next = wave_reg;
                    endcase
                end
                T8WM_PHASE_PWM: begin
                    // bottom/max compare: the edges cancel to a fixed level
                    if (cfg.out_action_sel[1]) begin
                        if (compare_reg == CNT_BOTTOM) begin
                            wave_next = cfg.out_action_sel[0]; // RULE_18
                        end else if (compare_reg == CNT_MAX) begin
                            wave_next = !cfg.out_action_sel[0]; // RULE_18
                        end else if (hit) begin
                            wave_next = down_reg ^ cfg.out_action_sel[0]; // RULE_16
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wave_reg <= 1'b0;
        end else begin
            wave_reg <= wave_next;
        end
    end

    // pin drives only with an action selected and direction set to output
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_wave_out <= 1'b0;
            o_wave_oe <= 1'b0;
        end else begin
            o_wave_out <= wave_reg;
            o_wave_oe <= dir_out && cfg.out_action_sel != T8WM_ACT_OFF; // RULE_19
        end
    end
endmodule

// ===== t8wm_timer_props.sv
/*
 * t8wm_timer_chk: bus handshake and event pulse checks on the timer top.
 * Assumes: bound to t8wm_timer; one clock, sync active-high reset.
 */
`timescale 1ns/10ps
module t8wm_timer_chk (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // bus
    input wire logic o_awready,
    input wire logic o_wready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_rready,
    // pin and events
    input wire logic o_wave_out,
    input wire logic o_wave_oe,
    input wire logic o_overflow_pulse,
    input wire logic o_match_pulse
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence b_wait;
        o_bvalid && !i_bready;
    endsequence
    sequence r_wait;
        o_rvalid && !i_rready;
    endsequence
    bvalid_hold_a: assert property (b_wait |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped early");
    rvalid_hold_a: assert property (r_wait |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped early");
    read_block_a: assert property (o_rvalid |-> !o_arready)
        else $error("read address taken during response");
    write_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write taken during response");
    match_pulse_a: assert property (o_match_pulse |=> !o_match_pulse)
        else $error("match pulse longer than one cycle");
    ovf_pulse_a: assert property (o_overflow_pulse |=> !o_overflow_pulse)
        else $error("overflow pulse longer than one cycle");
    oe_reset_a: assert property ($fell(i_rst) |-> !o_wave_oe)
        else $error("pin driven right after reset");
    rst_quiet_a: assert property (disable iff (1'b0)
        i_rst |=> !o_wave_out && !o_match_pulse && !o_overflow_pulse)
        else $error("outputs active in reset");
endmodule

bind t8wm_timer t8wm_timer_chk i_t8wm_timer_chk (.*);

// ===== testbench.sv
/*
 * testbench: drives the timer over AXI4-Lite and its tick pin.
 * Assumes: internal tick lands within three clocks of a pin rising edge.
 */
`timescale 1ns/10ps
module testbench;
    logic i_clock = 0, i_rst = 1, i_tick_pin = 0;
    logic [4:0] i_awaddr = 0, i_araddr = 0;
    logic [31:0] i_wdata = 0, o_rdata, d;
    logic [3:0] i_wstrb = 4'hF;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0;
    logic i_rready = 0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp;
    logic o_wave_out, o_wave_oe, o_overflow_pulse, o_match_pulse;
    int err_total = 0, cmp_count = 0, n_pulse = 0;
    always #25 i_clock = ~i_clock;
    t8wm_timer i_t8wm_timer (.*);
    // every event pulse, summed over the run
    always @(posedge i_clock)
        if (!i_rst) n_pulse += o_overflow_pulse + o_match_pulse;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        logic pa, pw;
        pa = 1;
        pw = 1;
        i_awaddr <= a;
        i_wdata <= v;
        i_awvalid <= 1;
        i_wvalid <= 1;
        while (pa || pw) begin
            @(posedge i_clock);
            if (pa && o_awready) begin i_awvalid <= 0; pa = 0; end
            if (pw && o_wready) begin i_wvalid <= 0; pw = 0; end
        end
        // late ready lets the response wait once
        while (!o_bvalid) @(posedge i_clock);
        i_bready <= 1;
        @(posedge i_clock);
        chk({30'h0, o_bresp}, {30'h0, ((a > 5'h10) ? 2'b10 : 2'b00)});
        i_bready <= 0;
        @(posedge i_clock);
    endtask
    task automatic rc(input logic [4:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        i_araddr <= a;
        i_arvalid <= 1;
        do @(posedge i_clock); while (!o_arready);
        i_arvalid <= 0;
        while (!o_rvalid) @(posedge i_clock);
        i_rready <= 1;
        @(posedge i_clock);
        d = o_rdata;
        i_rready <= 0;
        if (m == 0) chk({30'h0, o_rresp}, {30'h0, 2'b10});
        else chk(d & m, e);
        @(posedge i_clock);
    endtask
    // six clocks per tick keeps the pin slow against the synchroniser
    task automatic tk(input int n);
        repeat (n) begin
            i_tick_pin <= 1;
            repeat (3) @(posedge i_clock);
            i_tick_pin <= 0;
            repeat (3) @(posedge i_clock);
        end
    endtask
    task automatic report_and_stop;
        if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge i_clock);
        i_rst <= 0;
        @(posedge i_clock);
        rc(5'h00, 32'hFFFFFFFF, 32'h0);
        rc(5'h14, 32'h0, 32'h0);
        wr(5'h14, 32'h1);
        wr(5'h08, 32'h3);
        wr(5'h00, 32'h342);
        tk(6);
        rc(5'h04, 32'hFF, 32'h2);
        rc(5'h0C, 32'h7, 32'h6);
        chk({30'h0, o_wave_oe, o_wave_out}, 32'h3);
        wr(5'h0C, 32'h3);
        wr(5'h04, 32'hFE);
        tk(3);
        rc(5'h04, 32'hFF, 32'h1);
        rc(5'h0C, 32'h1, 32'h1);
        wr(5'h00, 32'h142);
        tk(4);
        rc(5'h04, 32'hFF, 32'h1);
        wr(5'h00, 32'h383);
        wr(5'h08, 32'h10);
        wr(5'h04, 32'hFE);
        wr(5'h0C, 32'h3);
        tk(2);
        rc(5'h04, 32'hFF, 32'h0);
        rc(5'h0C, 32'h5, 32'h5);
        tk(16);
        rc(5'h0C, 32'h4, 32'h4);
        tk(1);
        rc(5'h0C, 32'h4, 32'h0);
        wr(5'h00, 32'h381);
        wr(5'h04, 32'hFE);
        tk(3);
        rc(5'h04, 32'hFF, 32'hFD);
        wr(5'h04, 32'h12);
        tk(3);
        rc(5'h0C, 32'h4, 32'h4);
        wr(5'h04, 32'h1);
        wr(5'h0C, 32'h3);
        tk(2);
        rc(5'h0C, 32'h3, 32'h3);
        wr(5'h00, 32'h342);
        wr(5'h08, 32'h0);
        wr(5'h04, 32'h0);
        tk(2);
        rc(5'h0C, 32'h4, 32'h0);
        tk(1);
        rc(5'h0C, 32'h4, 32'h4);
        wr(5'h00, 32'h380);
        tk(2);
        rc(5'h04, 32'hFF, 32'h2);
        rc(5'h0C, 32'h4, 32'h0);
        wr(5'h00, 32'h3C0);
        wr(5'h10, 32'h1);
        rc(5'h0C, 32'h4, 32'h4);
        chk(n_pulse, 32'h9);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        err_total++;
        report_and_stop();
    end
endmodule
